// File: rtl/phyec_pkg.sv
// package of the phy event counter and pcs configuration block
// assumes a 25 MHz ref_clk and a 5-bit management register address
package phyec_pkg;

  // ==========================================================
  // bus shape
  localparam int ADDR_W = 5;   // register address width
  localparam int DATA_W = 16;  // register data width
  localparam int CNT_W  = 8;   // event counter width

  // ==========================================================
  // register offsets
  localparam logic [4:0] OFS_FALSE_CARRIER = 5'h14;  // false_carrier_count
  localparam logic [4:0] OFS_RX_ERROR      = 5'h15;  // receive_error_count
  localparam logic [4:0] OFS_PCS_CONFIG    = 5'h16;  // pcs_sublayer_config
  localparam logic [4:0] OFS_IRQ_STATUS    = 5'h18;  // event status, write one to clear
  localparam logic [4:0] OFS_IRQ_MASK      = 5'h19;  // event mask, one enables

  // ==========================================================
  // pcs_sublayer_config field positions
  localparam int CFG_TX_SILENT   = 10;  // transmit_silent_enable
  localparam int CFG_FORCE_SD    = 9;   // force_signal_detect
  localparam int CFG_SD_ALGO     = 8;   // signal_detect_algorithm
  localparam int CFG_DESCRAMBLER_TIMEOUT_SELECT   = 7;   // descrambler_timeout_select
  localparam int CFG_FORCE_100   = 5;   // force 100 Mb/s link good
  localparam int CFG_NRZI_BYPASS = 2;   // nrzi bypass
  localparam logic [15:0] CFG_RESET = 16'h0100;  // only the algorithm bit set
  localparam logic [15:0] CFG_WMASK = 16'h07A4;  // bits that hold a value

  // ==========================================================
  // interrupt status / mask field positions
  localparam int IRQ_W        = 3;
  localparam int IRQ_FC       = 0;  // false carrier event
  localparam int IRQ_RXERR    = 1;  // receive error counted
  localparam int IRQ_SYNCLOST = 2;  // descrambler timeout
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;       // 25 MHz
  localparam int DESC_SHORT_NS = 722000;   // 722 us
  localparam int DESC_LONG_NS  = 2000000;  // 2 ms
  localparam int DESC_SHORT_CYC = DESC_SHORT_NS / CLK_PERIOD_NS;
  localparam int DESC_LONG_CYC  = DESC_LONG_NS / CLK_PERIOD_NS;
  localparam int DESC_CNT_W     = 16;      // holds both counts

  // receive error tracker states
  typedef enum logic [0:0] {RX_IDLE, RX_CARRIER} phyec_rx_state_t;

endpackage

// File: rtl/phyec_sat_counter.sv
// saturating event counter with clear-on-read
// assumes inc and clr come from logic on ref_clk
`timescale 1ns/1ps
module phyec_sat_counter
  import phyec_pkg::*;
#(
  parameter int W = CNT_W
)(
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         inc,      // one-cycle event pulse
  input  wire logic         clr,      // one-cycle read clear
  output logic [W-1:0]      count_q   // current tally
);
  localparam logic [W-1:0] MAXV = '1;

  // ==========================================================
  // counter: a clear still keeps an event of the same cycle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      count_q <= '0;
    else if (clr)
      count_q <= inc ? W'(1) : '0;  // RULE3
    else if (inc && count_q != MAXV)  // RULE2 RULE8
      count_q <= count_q + W'(1);  // RULE1
  end

  chk_count_inc: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
    inc && !clr && count_q != MAXV |=> count_q == $past(count_q) + W'(1))
    else $error("counter did not advance");
  chk_sat_hold: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2 RULE8
    count_q == MAXV && !clr |=> count_q == MAXV)
    else $error("counter left full scale");
endmodule

// File: rtl/phyec_desc_timer.sv
// descrambler loss-of-sync timer with two selectable lengths
// assumes sync_seen is a pulse from the descrambler on ref_clk
`timescale 1ns/1ps
module phyec_desc_timer
  import phyec_pkg::*;
#(
  parameter int SHORT_CYC = DESC_SHORT_CYC,
  parameter int LONG_CYC  = DESC_LONG_CYC
)(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic long_sel,   // 1 selects the long timeout
  input  wire logic sync_seen,  // restarts the wait
  output logic      lost_q      // one-cycle timeout pulse
);
  logic [DESC_CNT_W-1:0] cnt_q;    // cycles since last sync
  logic [DESC_CNT_W-1:0] limit;    // active timeout length

  assign limit = long_sel ? DESC_CNT_W'(LONG_CYC - 1) : DESC_CNT_W'(SHORT_CYC - 1);

  // ==========================================================
  // count cycles, wrap and pulse on expiry
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q  <= '0;
      lost_q <= 1'b0;
    end
    else
    begin
      lost_q <= 1'b0;
      if (sync_seen)
        cnt_q <= '0;
      else if (cnt_q >= limit)
      begin
        cnt_q  <= '0;
        lost_q <= 1'b1;  // RULE12
      end
      else
        cnt_q <= cnt_q + DESC_CNT_W'(1);
    end
  end

  chk_timeout_len: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE12
    lost_q |-> $past(cnt_q) == $past(limit))
    else $error("timeout at wrong count");
endmodule

// File: rtl/phyec_regs.sv
// phy event counters and pcs sub-layer configuration registers
// assumes event inputs come from receive logic on ref_clk and a
// management port with read data one cycle after the read strobe
//
// Operation
// [RULE1] false carrier tally counts each false carrier
// [RULE2] false carrier tally sticks at all ones
// [RULE3] counters read-only, reset zero, cleared by read
// [RULE4] unused upper bits ignore writes, read zero
// [RULE5] count invalid symbol during valid carrier
// [RULE6] at most one count per carrier event
// [RULE7] no count when collision during carrier
// [RULE8] receive error tally saturates, never wraps
// [RULE9] bit 10 selects transmit true quiet
// [RULE10] bit 9 forces signal detect active
// [RULE11] bit 8 picks enhanced detect, resets one
// [RULE12] bit 7 lengthens descrambler timeout
// [RULE13] bit 5 forces 100 Mb/s link good
// [RULE14] bit 2 bypasses the nrzi stage
// [RULE15] software keeps reserved config bits zero; the bench writes bits 15:13 set in its config words
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module phyec_regs
  import phyec_pkg::*;
#(
  parameter int SHORT_CYC = DESC_SHORT_CYC,  // short descrambler timeout
  parameter int LONG_CYC  = DESC_LONG_CYC    // long descrambler timeout
)(
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              false_carrier_evt,
  input  wire logic              carrier_valid,
  input  wire logic              invalid_symbol,
  input  wire logic              collision,
  input  wire logic              sd_raw,
  input  wire logic              link100_raw,
  input  wire logic              desc_sync_seen,
  output logic                   transmit_silent_enable,
  output logic                   force_signal_detect,
  output logic                   signal_detect_algorithm,
  output logic                   descrambler_timeout_select,
  output logic                   nrzi_bypass,
  output logic                   signal_detect,
  output logic                   link100_good,
  output logic                   desc_sync_lost,
  output logic                   irq
);

  // ==========================================================
  // declarations
  logic [DATA_W-1:0] cfg_q;            // configuration register
  logic [IRQ_W-1:0]  irq_stat_q;       // sticky event bits
  logic [IRQ_W-1:0]  irq_mask_q;       // interrupt enables
  logic [IRQ_W-1:0]  irq_evt;          // this cycle's events
  logic [DATA_W-1:0] rdata_d;          // read mux result
  logic [CNT_W-1:0]  fc_tally;         // false_carrier_tally
  logic [CNT_W-1:0]  rx_tally;         // receive_symbol_error_tally
  logic              fc_clr;           // read of false carrier count
  logic              rx_clr;           // read of receive error count
  logic              rx_inc;           // one count per carrier event
  logic              err_seen_q;       // invalid symbol in this carrier
  logic              col_seen_q;       // collision in this carrier
  logic              sync_lost;        // timer expiry pulse
  phyec_rx_state_t   rx_state_q;       // carrier tracker state
  phyec_rx_state_t   rx_state_d;       // next tracker state

  // ==========================================================
  // clear-on-read strobes
  // a read strobe on a counter's offset clears that counter, leaving 1 when an event lands in the same cycle
  assign fc_clr = reg_rd && reg_addr == OFS_FALSE_CARRIER;  // RULE3
  assign rx_clr = reg_rd && reg_addr == OFS_RX_ERROR;       // RULE3

  // ==========================================================
  // false carrier tally
  phyec_sat_counter #(
    .W       (CNT_W)
  ) u_fc_cnt (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .inc     (false_carrier_evt),  // RULE1
    .clr     (fc_clr),
    .count_q (fc_tally)
  );

  // ==========================================================
  // carrier event tracker
  // next state follows the carrier level
  always_comb
  begin
    rx_state_d = rx_state_q;
    case (rx_state_q)
      RX_IDLE:
      begin
        // carrier starts a new event
        if (carrier_valid)
          rx_state_d = RX_CARRIER;
      end
      RX_CARRIER:
      begin
        // carrier end closes the event
        if (!carrier_valid)
          rx_state_d = RX_IDLE;
      end
      default:
        rx_state_d = RX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rx_state_q <= RX_IDLE;
    else
      rx_state_q <= rx_state_d;
  end

  // remember an invalid symbol seen while the carrier is valid
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      err_seen_q <= 1'b0;
    else if (!carrier_valid)
      err_seen_q <= 1'b0;  // new event starts clean
    else if (invalid_symbol)
      err_seen_q <= 1'b1;  // RULE5
  end

  // remember a collision anywhere in the carrier event
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      col_seen_q <= 1'b0;
    else if (!carrier_valid)
      col_seen_q <= 1'b0;
    else if (collision)
      col_seen_q <= 1'b1;  // RULE7
  end

  // commit once, at the end of the carrier; deciding at the end
  // lets a late collision still veto the count
  assign rx_inc = rx_state_q == RX_CARRIER && !carrier_valid
                  && err_seen_q && !col_seen_q;  // RULE5 RULE6 RULE7

  // ==========================================================
  // receive error tally
  phyec_sat_counter #(
    .W       (CNT_W)
  ) u_rx_cnt (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .inc     (rx_inc),  // RULE8
    .clr     (rx_clr),
    .count_q (rx_tally)
  );

  // ==========================================================
  // pcs sub-layer configuration, only defined bits hold a value
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_q <= CFG_RESET;  // RULE11
    else if (reg_wr && reg_addr == OFS_PCS_CONFIG)
      cfg_q <= reg_wdata & CFG_WMASK;  // RULE4
  end

  // configuration outputs
  assign transmit_silent_enable     = cfg_q[CFG_TX_SILENT];    // RULE9
  assign force_signal_detect        = cfg_q[CFG_FORCE_SD];     // RULE10
  assign signal_detect_algorithm    = cfg_q[CFG_SD_ALGO];      // RULE11
  assign descrambler_timeout_select = cfg_q[CFG_DESCRAMBLER_TIMEOUT_SELECT];    // RULE12
  assign nrzi_bypass                = cfg_q[CFG_NRZI_BYPASS];  // RULE14

  // forced indications override the measured ones
  assign signal_detect = sd_raw | cfg_q[CFG_FORCE_SD];         // RULE10
  assign link100_good  = link100_raw | cfg_q[CFG_FORCE_100];   // RULE13

  // ==========================================================
  // descrambler timeout
  phyec_desc_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_desc (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .long_sel  (cfg_q[CFG_DESCRAMBLER_TIMEOUT_SELECT]),  // RULE12
    .sync_seen (desc_sync_seen),
    .lost_q    (sync_lost)
  );
  assign desc_sync_lost = sync_lost;

  // ==========================================================
  // interrupt status and mask
  // bit 0 false carrier, bit 1 receive error, bit 2 sync lost
  assign irq_evt = {sync_lost, rx_inc, false_carrier_evt};

  // sticky bits: an event in a clearing cycle survives
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_stat_q <= '0;
    else if (reg_wr && reg_addr == OFS_IRQ_STATUS)
      irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
    else
      irq_stat_q <= irq_stat_q | irq_evt;
  end

  // mask register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_mask_q <= IRQ_MASK_RESET;
    else if (reg_wr && reg_addr == OFS_IRQ_MASK)
      irq_mask_q <= reg_wdata[IRQ_W-1:0];
  end

  // level interrupt
  assign irq = |(irq_stat_q & irq_mask_q);

  // ==========================================================
  // read path: mux, then register for the next cycle
  // unmapped offsets and unused bits read zero
  always_comb
  begin
    rdata_d = '0;
    case (reg_addr)
      OFS_FALSE_CARRIER:
        rdata_d = {{(DATA_W-CNT_W){1'b0}}, fc_tally};  // RULE4
      OFS_RX_ERROR:
        rdata_d = {{(DATA_W-CNT_W){1'b0}}, rx_tally};  // RULE4
      OFS_PCS_CONFIG:
        rdata_d = cfg_q;  // upper bits never stored
      OFS_IRQ_STATUS:
        rdata_d = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
      OFS_IRQ_MASK:
        rdata_d = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
      default:
        rdata_d = '0;  // unmapped reads zero
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= '0;
  end

  // ==========================================================
  // checks, all on ref_clk and quiet while reset is low

  // a read of the false carrier count clears it
  chk_cor_clear: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE3
    fc_clr && !false_carrier_evt |=> fc_tally == '0)
    else $error("false carrier tally not cleared by read");

  // a read returns the false carrier tally held before the clear
  chk_fc_read: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE3
    fc_clr |=> reg_rdata[CNT_W-1:0] == $past(fc_tally))
    else $error("read did not return false carrier tally");

  // a read returns the receive error tally held before the clear
  chk_read_old: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE3
    rx_clr |=> reg_rdata[CNT_W-1:0] == $past(rx_tally))
    else $error("read did not return tally before clear");

  // read data stands for one cycle only, zero otherwise
  chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside the answer cycle");

  // config bits 15:13 read zero
  chk_cfg_upper: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE4
    reg_rd && reg_addr == OFS_PCS_CONFIG |=> reg_rdata[15:13] == 3'h0)
    else $error("config upper bits not zero");

  // upper counter bits read zero
  chk_cnt_upper: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE4
    reg_rd && (reg_addr == OFS_RX_ERROR || reg_addr == OFS_FALSE_CARRIER)
    |=> reg_rdata[15:8] == 8'h00)
    else $error("counter upper bits not zero");

  // a bad symbol in a clean carrier is counted at its end
  chk_rx_cause: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE5
    carrier_valid && invalid_symbol && !collision && !col_seen_q
    ##1 !carrier_valid |-> rx_inc)
    else $error("receive error not counted");

  // every count lands in the tally, even beside a read clear
  chk_rx_tally: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE5
    rx_inc |=> rx_tally != '0)
    else $error("receive error count lost");

  // a count closes the carrier event and is not repeated
  chk_rx_once: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE6
    rx_inc |-> $past(carrier_valid) && !carrier_valid ##1 !rx_inc)
    else $error("second count in one carrier event");

  // a collision in the next-to-last carrier cycle vetoes the count
  chk_rx_coll: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE7
    carrier_valid && collision ##1 carrier_valid [*1] ##1 !carrier_valid
    |-> !rx_inc)
    else $error("count despite collision");

  // each event leaves its status bit set, even through a clear
  chk_stat_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq_evt != '0 |=> (irq_stat_q & $past(irq_evt)) == $past(irq_evt))
    else $error("event lost from status");

  // writing ones clears those status bits when no event arrives
  chk_irq_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    reg_wr && reg_addr == OFS_IRQ_STATUS && irq_evt == '0
    |=> (irq_stat_q & $past(reg_wdata[IRQ_W-1:0])) == '0)
    else $error("status bits not cleared by write");

  // forced signal detect
  chk_sd_force: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE10
    reg_wr && reg_addr == OFS_PCS_CONFIG && reg_wdata[CFG_FORCE_SD]
    |=> signal_detect && force_signal_detect)
    else $error("signal detect not forced");

  // forced link good
  chk_link_force: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE13
    reg_wr && reg_addr == OFS_PCS_CONFIG && reg_wdata[CFG_FORCE_100]
    |=> link100_good)
    else $error("100 Mb/s link not forced good");

  // written true quiet and nrzi bypass bits appear on the outputs
  chk_cfg_write: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE9 RULE14
    reg_wr && reg_addr == OFS_PCS_CONFIG
    |=> transmit_silent_enable == $past(reg_wdata[CFG_TX_SILENT])
        && nrzi_bypass == $past(reg_wdata[CFG_NRZI_BYPASS]))
    else $error("config write not applied");

endmodule

// File: tb/test_phyec_regs.sv
// self-checking bench for the phy event counters and pcs configuration block
// assumes phyec_pkg and phyec_regs are compiled first; timeouts shortened
`timescale 1ns/1ps
module test_phyec_regs;
  import phyec_pkg::*;

  // ==========================================================
  // signals
  localparam int SC = 20;  // shortened short timeout
  localparam int LC = 50;  // shortened long timeout
  localparam logic [15:0] CFG_SW_KEEP = 16'hE7A4;  // clears must-be-zero config bits 12:11, 6, 4:3 and 1:0, but lets bits 15:13 through
  logic              ref_clk = 1'b0;
  logic              arst_n  = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0, reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              false_carrier_evt = 1'b0, carrier_valid = 1'b0;
  logic              invalid_symbol = 1'b0, collision = 1'b0;
  logic              sd_raw = 1'b0, link100_raw = 1'b0, desc_sync_seen = 1'b1;
  logic              tx_sil, f_sd, sd_alg, desc_sel, nrzi, sd_out, l100, lost, irq;
  logic [15:0]       exp_q[$];       // expected read data, oldest first
  logic              rd_pend = 1'b0; // a read answer is due this cycle
  int                err_count = 0;
  int                comparisons = 0;
  logic [15:0]       d;
  int                n;

  // clock at 25 MHz
  always #20 ref_clk = ~ref_clk;

  phyec_regs #(.SHORT_CYC(SC), .LONG_CYC(LC)) dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .false_carrier_evt(false_carrier_evt), .carrier_valid(carrier_valid),
    .invalid_symbol(invalid_symbol), .collision(collision), .sd_raw(sd_raw),
    .link100_raw(link100_raw), .desc_sync_seen(desc_sync_seen),
    .transmit_silent_enable(tx_sil), .force_signal_detect(f_sd),
    .signal_detect_algorithm(sd_alg), .descrambler_timeout_select(desc_sel),
    .nrzi_bypass(nrzi), .signal_detect(sd_out), .link100_good(l100),
    .desc_sync_lost(lost), .irq(irq));

  // ==========================================================
  // reporting
  task automatic complete_run();
    if (exp_q.size() != 0)
    begin
      err_count++;
      $display("[FAIL] %0t noted read answers never came", $time);
    end
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s: got %b expected %b", $time, m, got, exp);
    end
  endtask

  // ==========================================================
  // drivers: each call of bus, wr, rd or ev is one clock cycle
  // bus cycle; event lines drop to idle meanwhile
  task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= v;
    false_carrier_evt <= 1'b0;
    carrier_valid <= 1'b0;
    invalid_symbol <= 1'b0;
    collision <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    bus(1'b1, 1'b0, a, v);
  endtask

  // the expected answer is noted before the strobe goes out
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask

  // event cycle; strobes drop to idle meanwhile
  task automatic ev(input logic fc, input logic cv, input logic iv, input logic co);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    false_carrier_evt <= fc;
    carrier_valid <= cv;
    invalid_symbol <= iv;
    collision <= co;
  endtask

  // quiet cycles; returns just after the last edge so outputs have settled
  task automatic idle(input int k);
    repeat (k) ev(1'b0, 1'b0, 1'b0, 1'b0);
    #1;
  endtask

  // one carrier of len cycles; bad marks every symbol invalid, col a late collision
  task automatic carrier(input int len, input logic bad, input logic col);
    for (int i = 0; i < len; i++)
      ev(1'b0, 1'b1, bad, col && (i == len - 2));
    idle(2);
  endtask

  // bounded wait for the timeout pulse, cycles counted in n
  task automatic wait_lost();
    n = 0;
    while (lost !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 200)
    begin
      err_count++;
      $display("[FAIL] %0t timeout pulse never came", $time);
      complete_run();
    end
  endtask

  // ==========================================================
  // monitor: a read answer stands in the cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rd_pend)
    begin
      if (exp_q.size() == 0)
        chk_word(reg_rdata, 16'hxxxx, "unexpected read answer");
      else
        chk_word(reg_rdata, exp_q.pop_front(), "read data");
    end
    rd_pend <= reg_rd;
  end

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    $display("[FAIL] %0t run did not finish", $time);
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(43011));
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    // reset values
    rd(OFS_PCS_CONFIG, CFG_RESET);
    rd(OFS_FALSE_CARRIER, 16'h0000);
    rd(OFS_RX_ERROR, 16'h0000);
    idle(2);
    chk_pin(sd_alg, 1'b1, "algorithm after reset");
    chk_pin(tx_sil | f_sd | desc_sel | nrzi, 1'b0, "config after reset");
    // configuration: fixed extremes then random words
    for (int k = 0; k < 6; k++)
    begin
      d = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
      wr(OFS_PCS_CONFIG, d & CFG_SW_KEEP);
      sd_raw <= d[0];
      link100_raw <= d[1];
      idle(1);
      chk_pin(tx_sil, d[10], "true quiet bit");
      chk_pin(f_sd, d[9], "force detect bit");
      chk_pin(sd_alg, d[8], "algorithm bit");
      chk_pin(desc_sel, d[7], "timeout select bit");
      chk_pin(l100, d[1] | d[5], "link good");
      chk_pin(nrzi, d[2], "nrzi bypass bit");
      chk_pin(sd_out, d[0] | d[9], "signal detect");
      rd(OFS_PCS_CONFIG, d & CFG_WMASK);
    end
    wr(OFS_PCS_CONFIG, CFG_RESET);
    // counters refuse writes; unmapped reads give zero
    wr(OFS_FALSE_CARRIER, 16'hFFFF);
    wr(OFS_RX_ERROR, 16'hFFFF);
    rd(OFS_FALSE_CARRIER, 16'h0000);
    rd(OFS_RX_ERROR, 16'h0000);
    rd(5'h1F, 16'h0000);
    // false carrier tally, random count and gaps
    n = $urandom_range(1, 40);
    for (int i = 0; i < n; i++)
    begin
      ev(1'b1, 1'b0, 1'b0, 1'b0);
      idle($urandom_range(0, 2));
    end
    idle(2);
    rd(OFS_FALSE_CARRIER, 16'(n));
    rd(OFS_FALSE_CARRIER, 16'h0000);
    repeat (300) ev(1'b1, 1'b0, 1'b0, 1'b0);
    idle(2);
    rd(OFS_FALSE_CARRIER, 16'h00FF);
    // receive error tally: one per bad carrier, none on collision
    carrier(5, 1'b1, 1'b0);
    carrier(5, 1'b0, 1'b0);
    carrier(5, 1'b1, 1'b1);
    ev(1'b0, 1'b0, 1'b1, 1'b0);
    idle(2);
    rd(OFS_RX_ERROR, 16'h0001);
    repeat (260) carrier(2, 1'b1, 1'b0);
    rd(OFS_RX_ERROR, 16'h00FF);
    rd(OFS_RX_ERROR, 16'h0000);
    // interrupt: raise, clear, mask
    wr(OFS_IRQ_STATUS, 16'h0007);
    wr(OFS_IRQ_MASK, 16'h0001);
    rd(OFS_IRQ_MASK, 16'h0001);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    idle(1);
    chk_pin(irq, 1'b1, "irq after false carrier");
    wr(OFS_IRQ_STATUS, 16'h0001);
    idle(1);
    chk_pin(irq, 1'b0, "irq after clear");
    wr(OFS_IRQ_MASK, 16'h0000);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    carrier(3, 1'b1, 1'b0);
    chk_pin(irq, 1'b0, "masked irq");
    rd(OFS_IRQ_STATUS, 16'h0003);
    wr(OFS_IRQ_MASK, 16'h0002);
    idle(1);
    chk_pin(irq, 1'b1, "irq on receive error");
    wr(OFS_IRQ_STATUS, 16'h0003);
    idle(1);
    chk_pin(irq, 1'b0, "irq after clear");
    rd(OFS_FALSE_CARRIER, 16'h0002);
    rd(OFS_RX_ERROR, 16'h0001);
    // descrambler timeout, short then long
    wr(OFS_IRQ_MASK, 16'h0004);
    for (int k = 0; k < 2; k++)
    begin
      ev(1'b0, 1'b0, 1'b0, 1'b0);
      desc_sync_seen <= 1'b0;
      wait_lost();
      chk_pin(logic'(n == (k ? LC : SC)), 1'b1, "timeout length");
      @(posedge ref_clk);
      desc_sync_seen <= 1'b1;
      #1;
      chk_pin(lost, 1'b0, "timeout pulse width");
      chk_pin(irq, 1'b1, "irq on timeout");
      wr(OFS_IRQ_STATUS, 16'h0004);
      wr(OFS_PCS_CONFIG, 16'h0180);
    end
    idle(3);
    chk_pin(irq, 1'b0, "irq after timeout clear");
    complete_run();
  end
endmodule
